/* core/switch_diag_map.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: apb byte addressing, one 32-bit word per register
// Notes: included by the design file
`ifndef SWITCH_DIAG_MAP_SVH
`define SWITCH_DIAG_MAP_SVH

`define ADDR_FAULT 12'h000
`define ADDR_CHCFG 12'h004
`define ADDR_GENCFG 12'h008
`define ADDR_OCCFG 12'h00C
`define ADDR_STATE 12'h010

// fault_register fields, channel 1 at +4
`define FLT_OPEN_LOAD_ON_FLAG 0
`define FLT_OLOFF 1
`define FLT_OS 2
`define FLT_CH1 4

// channel_config_register fields, channel 1 at +16
`define CFG_DIR_DIS 5
`define CFG_OS_DIS 6
`define CFG_OLOFF_DIS 7
`define CFG_OPEN_LOAD_ON_FLAG_DIS 8
`define CFG_FAST_SLEW 9
`define CFG_INT_PWM 10
`define CFG_MOTOR 11
`define CFG_CH1 16

// general_config_register fields
`define GEN_SEL0 0
`define GEN_SEL1 1
`define GEN_TH 2

// overcurrent_config_register fields
`define OC_LOW_RATIO 0

`define CHCFG_RST 32'h0000_0000
`define GENCFG_RST 32'h0000_0000
`define OCCFG_RST 32'h0000_0000

// periodic open-load check interval
`define OLLED_MS 150
`define CLK_MHZ 250
`define OLLED_CYC (`OLLED_MS * 1000 * `CLK_MHZ)

`endif

/* core/switch_diag_pkg.sv */
// Purpose: shared types of the diagnostic block
// Assumes: nothing
// Notes: constants live in switch_diag_map.svh
package switch_diag_pkg;
	typedef enum logic [1:0] {
		SENSE_OFF,
		SENSE_CH0,
		SENSE_CH1,
		SENSE_TEMP
	} sense_src_t;
endpackage : switch_diag_pkg

/* core/switch_diag_and_sense_ctrl.sv */
// Purpose: diagnostic flags, duration counter clears and sense control for two channels
// Assumes: analog comparators and channel state arrive as pins, synchronised here
// Notes: apb slave, no wait states
//
// Summary of operation
// - lighting profile: clear duration counter each retry
// - motor: clear at first clean period turn-off
// - diagnostics set flags, never switch off
// - disable bits D8..D6 suppress each diagnostic
// - short check only when off, pin low
// - short flag sticky until fault read
// - off open-load each off period, pin follows
// - on open-load: pin low in high ratio only, flag set, stays on
// - high ratio: read clears open-load-on conditionally
// - low ratio: periodic check, fast slew only
// - internal pwm: check after 150 ms turn-off
// - direct input: check every turn-off
// - low ratio: clear after fault-free check read
// - two select bits choose sense source
// - over-current window: sense off, sync high
// - mode bit: synchronous or track-and-hold
// - ratio bit selects ratio, lowers thresholds
// - synchronous: sync low once settled till off
// - track-and-hold: sample and sync high at off
`timescale 1ns/10ps
`include "switch_diag_map.svh"

module switch_diag_and_sense_ctrl #(
	parameter int unsigned OLLED_CYCLES = `OLLED_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// per-channel state from the power stage, asynchronous
	input wire logic [1:0] chan_on,
	input wire logic [1:0] retry_pulse,
	input wire logic [1:0] oc_seen,
	input wire logic [1:0] oc_window,
	input wire logic [1:0] sense_settled,
	// comparator outputs, asynchronous
	input wire logic [1:0] open_load_on_det,
	input wire logic [1:0] open_load_off_det,
	input wire logic [1:0] short_det,
	// outputs
	output logic [1:0] oc_count_clear,
	output logic [1:0] low_threshold,
	output logic [1:0] ol_on_check,
	output logic [1:0] sense_src,
	output logic sense_enable,
	output logic sense_hold,
	output logic sense_valid_out_n,
	output logic fault_status_pin_n
);

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers
	localparam int NIN = 16;
	logic [NIN-1:0] raw;
	logic [NIN-1:0] sy1_q;
	logic [NIN-1:0] sy2_q;
	assign raw = {short_det, open_load_off_det, open_load_on_det, sense_settled,
		oc_window, oc_seen, retry_pulse, chan_on};
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sy1_q <= 16'h0000;
			sy2_q <= 16'h0000;
		end else begin
			sy1_q <= raw;
			sy2_q <= sy1_q;
		end
	end
	wire [1:0] on_s = sy2_q[1:0];
	wire [1:0] retry_s = sy2_q[3:2];
	wire [1:0] ocs_s = sy2_q[5:4];
	wire [1:0] ocw_s = sy2_q[7:6];
	wire [1:0] settled_s = sy2_q[9:8];
	wire [1:0] open_load_on_flag_s = sy2_q[11:10];
	wire [1:0] oloff_s = sy2_q[13:12];
	wire [1:0] short_s = sy2_q[15:14];

	////////////////////////////////////////////////////////////////////////////
	// apb decode
	logic [31:0] chcfg_q;
	logic [31:0] gencfg_q;
	logic [31:0] occfg_q;
	logic [7:0] fault_q;
	logic [1:0] on_q;
	logic rd_done_q;
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire rd = acc && !pwrite;
	wire hit_fault = paddr == `ADDR_FAULT;
	wire hit_chcfg = paddr == `ADDR_CHCFG;
	wire hit_gencfg = paddr == `ADDR_GENCFG;
	wire hit_occfg = paddr == `ADDR_OCCFG;
	wire hit_state = paddr == `ADDR_STATE;
	wire mapped = hit_fault || hit_chcfg || hit_gencfg || hit_occfg || hit_state;
	wire fault_read = rd && hit_fault;
	wire [31:0] state_word = {16'h0000, 2'b00, ocw_s, 2'b00, on_q, 8'h00};
	wire [31:0] rd_mux = hit_fault ? {24'h000000, fault_q} :
		hit_chcfg ? chcfg_q :
		hit_gencfg ? gencfg_q :
		hit_occfg ? occfg_q :
		hit_state ? state_word : 32'h0000_0000;
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0000_0000;
			chcfg_q <= `CHCFG_RST;
			gencfg_q <= `GENCFG_RST;
			occfg_q <= `OCCFG_RST;
		end else begin
			if (psel && !penable && !pwrite)
				prdata <= rd_mux;
			if (wr && hit_chcfg)
				chcfg_q <= pwdata;
			if (wr && hit_gencfg)
				gencfg_q <= pwdata;
			if (wr && hit_occfg)
				occfg_q <= pwdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// shared config decode
	function automatic logic cfg_bit(input logic [31:0] c, input int ch, input int pos);
		cfg_bit = c[ch * `CFG_CH1 + pos];
	endfunction : cfg_bit

	wire low_ratio = occfg_q[`OC_LOW_RATIO];
	wire th_mode = gencfg_q[`GEN_TH];
	assign low_threshold = {low_ratio, low_ratio};

	////////////////////////////////////////////////////////////////////////////
	// per-channel diagnostics
	logic [1:0] off_edge;
	logic [1:0] on_edge;
	logic [1:0] chk_q;
	logic [1:0] chk_clean_q;
	logic [1:0] period_oc_q;
	logic [31:0] olled_cnt_q [2];
	logic [1:0] pin_fault;
	logic [7:0] fault_set;
	logic [7:0] fault_clr;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			on_q <= 2'b00;
		else
			on_q <= on_s;
	end
	assign off_edge = on_q & ~on_s;
	assign on_edge = ~on_q & on_s;

	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic full_on_q;
		wire dis_open_load_on_flag = cfg_bit(chcfg_q, c, `CFG_OPEN_LOAD_ON_FLAG_DIS);
		wire dis_oloff = cfg_bit(chcfg_q, c, `CFG_OLOFF_DIS);
		wire dis_os = cfg_bit(chcfg_q, c, `CFG_OS_DIS);
		wire fast = cfg_bit(chcfg_q, c, `CFG_FAST_SLEW);
		wire int_pwm = cfg_bit(chcfg_q, c, `CFG_INT_PWM) || cfg_bit(chcfg_q, c, `CFG_DIR_DIS);
		wire motor = cfg_bit(chcfg_q, c, `CFG_MOTOR);
		wire timer_done = olled_cnt_q[c] >= OLLED_CYCLES - 1;
		// low ratio periodic check instant
		wire chk_int = int_pwm && timer_done && (off_edge[c] || (on_s[c] && full_on_q));
		wire chk_dir = !int_pwm && off_edge[c];
		wire chk_now = low_ratio && fast && (chk_int || chk_dir) && !dis_open_load_on_flag;
		wire os_hit = !on_s[c] && short_s[c] && !dis_os;
		wire oloff_hit = !on_s[c] && oloff_s[c] && !dis_oloff;
		wire open_load_on_flag_hit = !dis_open_load_on_flag && open_load_on_flag_s[c] && (low_ratio ? chk_now : on_s[c]);
		assign ol_on_check[c] = chk_q[c];
		assign pin_fault[c] = os_hit || oloff_hit || (!dis_open_load_on_flag && on_s[c] && open_load_on_flag_s[c]
			&& !low_ratio);
		assign fault_set[c*`FLT_CH1 + `FLT_OPEN_LOAD_ON_FLAG] = open_load_on_flag_hit;
		assign fault_set[c*`FLT_CH1 + `FLT_OLOFF] = oloff_hit;
		assign fault_set[c*`FLT_CH1 + `FLT_OS] = os_hit;
		assign fault_set[c*`FLT_CH1 + 3] = 1'b0;
		// open-load-on clear conditions
		wire open_load_on_flag_clr_hi = !on_s[c] || !open_load_on_flag_s[c];
		wire open_load_on_flag_clr = low_ratio ? chk_clean_q[c] : open_load_on_flag_clr_hi;
		assign fault_clr[c*`FLT_CH1 + `FLT_OPEN_LOAD_ON_FLAG] = open_load_on_flag_clr;
		assign fault_clr[c*`FLT_CH1 + `FLT_OLOFF] = 1'b1;
		assign fault_clr[c*`FLT_CH1 + `FLT_OS] = 1'b1;
		assign fault_clr[c*`FLT_CH1 + 3] = 1'b1;
		// lighting: every retry; motor: first clean period turn-off
		assign oc_count_clear[c] = motor ? (off_edge[c] && !period_oc_q[c] && !ocs_s[c])
			: retry_s[c];

		always_ff @(posedge core_clk or negedge arst_n) begin
			if (!arst_n) begin
				olled_cnt_q[c] <= 32'h0000_0000;
				chk_q[c] <= 1'b0;
				full_on_q <= 1'b1;
				chk_clean_q[c] <= 1'b0;
				period_oc_q[c] <= 1'b0;
			end else begin
				olled_cnt_q[c] <= chk_now ? 32'h0000_0000 :
					(timer_done ? olled_cnt_q[c] : olled_cnt_q[c] + 32'h0000_0001);
				chk_q[c] <= chk_now;
				if (chk_now)
					chk_clean_q[c] <= !open_load_on_flag_s[c];
				else if (rd_done_q)
					chk_clean_q[c] <= 1'b0;
				if (chk_now)
					full_on_q <= 1'b1;
				else if (off_edge[c])
					full_on_q <= 1'b0;
				if (on_edge[c])
					period_oc_q[c] <= ocs_s[c];
				else if (ocs_s[c])
					period_oc_q[c] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky flags and fault pin; no automatic turn-off anywhere
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_q <= 8'h00;
			rd_done_q <= 1'b0;
			fault_status_pin_n <= 1'b1;
		end else begin
			rd_done_q <= fault_read;
			fault_q <= fault_set | (fault_q & ~(fault_clr & prdata[7:0] & {8{rd_done_q}}));
			fault_status_pin_n <= ~|pin_fault;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sense source, mode and sync
	logic sel_ch;
	logic sync_n_q;
	logic hold_q;
	wire [1:0] sel_bits = {gencfg_q[`GEN_SEL1], gencfg_q[`GEN_SEL0]};
	wire any_ocw = |ocw_s;
	assign sel_ch = sel_bits == 2'b10;
	wire sel_on = sel_ch ? on_s[1] : on_s[0];
	wire sel_settled = sel_ch ? settled_s[1] : settled_s[0];
	wire sel_off_edge = sel_ch ? off_edge[1] : off_edge[0];
	wire sel_is_chan = sel_bits == 2'b01 || sel_bits == 2'b10;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sense_src <= switch_diag_pkg::SENSE_OFF;
			sense_enable <= 1'b0;
			sync_n_q <= 1'b1;
			hold_q <= 1'b0;
		end else begin
			sense_src <= sel_bits;
			sense_enable <= sel_bits != 2'b00 && !any_ocw;
			if (any_ocw || !sel_is_chan)
				sync_n_q <= 1'b1;
			else if (sel_on && sel_settled)
				sync_n_q <= 1'b0;
			else if (!sel_on || sel_off_edge)
				sync_n_q <= 1'b1;
			if (!th_mode || sel_on)
				hold_q <= 1'b0;
			else if (sel_off_edge)
				hold_q <= 1'b1;
		end
	end
	assign sense_valid_out_n = sync_n_q;
	assign sense_hold = hold_q;

endmodule : switch_diag_and_sense_ctrl

/* verification/switch_diag_properties.sv */
// Purpose: port assertions of the diagnostic block
// Assumes: three-edge comparator latency, zero-wait apb
// Notes: bound to every instance of the block
`timescale 1ns/10ps
module switch_diag_properties (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// channel side
	input wire logic [1:0] chan_on,
	input wire logic [1:0] oc_window,
	input wire logic [1:0] open_load_on_det,
	input wire logic [1:0] open_load_off_det,
	input wire logic [1:0] short_det,
	input wire logic [1:0] ol_on_check,
	input wire logic sense_enable,
	input wire logic sense_valid_out_n,
	input wire logic fault_status_pin_n
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	wire det_any = |{open_load_on_det, open_load_off_det, short_det};
	wire acc = psel && penable;
	sequence s_quiet; !det_any [*5]; endsequence
	sequence s_oc_held; (oc_window == 2'b11) [*5]; endsequence
	sequence s_idle; (chan_on == 2'b00) [*5]; endsequence
	////////////////////////////////////////
	a_zero_wait: assert property (acc |-> pready)
		else $error("access without ready");
	a_unmapped_err: assert property (acc && paddr > 12'h010 |-> pslverr)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (acc && paddr inside {12'h000, 12'h004, 12'h008,
		12'h00C, 12'h010} |-> !pslverr) else $error("mapped access refused");
	a_pin_cause: assert property ($fell(fault_status_pin_n) |->
		$past(det_any, 2) || $past(det_any, 3) || $past(det_any, 4))
		else $error("fault pin low without cause");
	a_pin_release: assert property (s_quiet |-> fault_status_pin_n)
		else $error("fault pin held low");
	a_oc_blanks: assert property (s_oc_held |-> sense_valid_out_n && !sense_enable)
		else $error("sensing during over-current window");
	a_off_sync: assert property (s_idle |-> sense_valid_out_n)
		else $error("sync low with channels off");
	a_check_pulse: assert property (ol_on_check[0] |=> !ol_on_check[0])
		else $error("check pulse too long");
	a_reset_idle: assert property ($rose(arst_n) |-> fault_status_pin_n && sense_valid_out_n)
		else $error("pins active after reset");
endmodule : switch_diag_properties

bind switch_diag_and_sense_ctrl switch_diag_properties u_props (.core_clk(core_clk),
	.arst_n(arst_n), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .chan_on(chan_on), .oc_window(oc_window),
	.open_load_on_det(open_load_on_det), .open_load_off_det(open_load_off_det),
	.short_det(short_det), .ol_on_check(ol_on_check), .sense_enable(sense_enable),
	.sense_valid_out_n(sense_valid_out_n), .fault_status_pin_n(fault_status_pin_n));

/* verification/power_stage_model.sv */
// Purpose: power stage stand-in on the channel side
// Assumes: sense settles SETTLE cycles after turn-on
// Notes: drives channel state and settle flags
`timescale 1ns/10ps
module power_stage_model #(
	parameter int SETTLE = 4
) (
	// clock
	input wire logic core_clk,
	// command and state
	input wire logic [1:0] on_req,
	output logic [1:0] chan_on,
	output logic [1:0] sense_settled
);
	int cnt [2] = '{0, 0};
	initial chan_on = 2'b00;
	initial sense_settled = 2'b00;
	always @(posedge core_clk) begin
		for (int i = 0; i < 2; i++) begin
			chan_on[i] <= on_req[i];
			cnt[i] <= on_req[i] ? cnt[i] + 1 : 0;
			sense_settled[i] <= on_req[i] && cnt[i] >= SETTLE;
		end
	end
endmodule : power_stage_model

/* verification/switch_diag_and_sense_ctrl_bench.sv */
// Purpose: register and pin level tests of the diagnostic block
// Assumes: zero-wait apb, three-edge input latency
// Notes: short check interval of 50 cycles
`timescale 1ns/10ps
`include "switch_diag_map.svh"
module switch_diag_and_sense_ctrl_bench;
	logic core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, sense_enable, sense_hold, sense_valid_out_n, fault_status_pin_n;
	logic [1:0] on_req = 2'b00, retry_pulse = 2'b00, oc_seen = 2'b00, oc_window = 2'b00;
	logic [1:0] open_load_on_det = 2'b00, open_load_off_det = 2'b00, short_det = 2'b00;
	logic [1:0] chan_on, sense_settled, oc_count_clear, low_threshold, ol_on_check, sense_src;
	int errors = 0, check_count = 0, clr_n = 0, chk_n = 0, n;
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (oc_count_clear[0] === 1'b1) clr_n++;
		if (ol_on_check[0] === 1'b1) chk_n++;
	end
	switch_diag_and_sense_ctrl #(.OLLED_CYCLES(50)) dut (.core_clk(core_clk), .arst_n(arst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_on(chan_on),
		.retry_pulse(retry_pulse), .oc_seen(oc_seen), .oc_window(oc_window),
		.sense_settled(sense_settled), .open_load_on_det(open_load_on_det),
		.open_load_off_det(open_load_off_det), .short_det(short_det),
		.oc_count_clear(oc_count_clear), .low_threshold(low_threshold),
		.ol_on_check(ol_on_check), .sense_src(sense_src), .sense_enable(sense_enable),
		.sense_hold(sense_hold), .sense_valid_out_n(sense_valid_out_n),
		.fault_status_pin_n(fault_status_pin_n));
	power_stage_model stage (.core_clk(core_clk), .on_req(on_req), .chan_on(chan_on),
		.sense_settled(sense_settled));
	////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : check
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input string m);
		apb(1'b0, a, 32'h0);
		check(q, x, m);
	endtask : rd
	task automatic tick(input int c);
		repeat (c) @(posedge core_clk);
	endtask : tick
	task automatic retry;
		n = clr_n;
		retry_pulse <= 2'b01;
		tick(1);
		retry_pulse <= 2'b00;
		tick(6);
	endtask : retry
	task automatic end_of_test;
		if (errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		tick(5000);
		errors++;
		end_of_test();
	end
	////////////////////////////////////////
	initial begin
		tick(4);
		arst_n <= 1'b1;
		tick(1);
		rd(`ADDR_CHCFG, `CHCFG_RST, "chcfg reset");
		rd(`ADDR_GENCFG, `GENCFG_RST, "gencfg reset");
		rd(`ADDR_OCCFG, `OCCFG_RST, "occfg reset");
		apb(1'b0, 12'h020, 32'h0);
		check(32'(e), 32'h1, "unmapped");
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, `ADDR_GENCFG, 32'(s));
			tick(1);
			check(32'(sense_src), 32'(s), "sense select");
		end
		apb(1'b1, `ADDR_OCCFG, 32'h1);
		check(32'(low_threshold), 32'h3, "low ratio");
		apb(1'b1, `ADDR_OCCFG, 32'h0);
		short_det <= 2'b01;
		tick(4);
		check(32'(fault_status_pin_n), 32'h0, "short pin");
		short_det <= 2'b00;
		tick(4);
		rd(`ADDR_FAULT, 32'h4, "short flag");
		rd(`ADDR_FAULT, 32'h0, "short cleared");
		apb(1'b1, `ADDR_CHCFG, 32'h40);
		short_det <= 2'b01;
		tick(4);
		check(32'(fault_status_pin_n), 32'h1, "short masked");
		short_det <= 2'b00;
		rd(`ADDR_FAULT, 32'h0, "masked flag");
		apb(1'b1, `ADDR_CHCFG, 32'h0);
		open_load_off_det <= 2'b10;
		tick(4);
		check(32'(fault_status_pin_n), 32'h0, "off open-load pin");
		open_load_off_det <= 2'b00;
		tick(4);
		check(32'(fault_status_pin_n), 32'h1, "off open-load gone");
		rd(`ADDR_FAULT, 32'h20, "off open-load flag");
		on_req <= 2'b01;
		open_load_on_det <= 2'b01;
		tick(6);
		check(32'(fault_status_pin_n), 32'h0, "on open-load pin");
		rd(`ADDR_FAULT, 32'h1, "open_load_on_flag set");
		rd(`ADDR_FAULT, 32'h1, "open_load_on_flag kept");
		open_load_on_det <= 2'b00;
		tick(4);
		rd(`ADDR_FAULT, 32'h1, "open_load_on_flag sticky");
		rd(`ADDR_FAULT, 32'h0, "open_load_on_flag cleared");
		open_load_on_det <= 2'b01;
		tick(6);
		on_req <= 2'b00;
		tick(4);
		rd(`ADDR_FAULT, 32'h1, "open_load_on_flag off read");
		rd(`ADDR_FAULT, 32'h0, "open_load_on_flag off cleared");
		open_load_on_det <= 2'b00;
		apb(1'b1, `ADDR_GENCFG, 32'h1);
		on_req <= 2'b01;
		tick(12);
		check(32'(sense_valid_out_n), 32'h0, "sync settled");
		oc_window <= 2'b11;
		tick(6);
		check(32'({sense_valid_out_n, sense_enable}), 32'h2, "oc window");
		oc_window <= 2'b00;
		on_req <= 2'b00;
		tick(6);
		check(32'({sense_valid_out_n, sense_hold}), 32'h2, "sync off");
		apb(1'b1, `ADDR_GENCFG, 32'h5);
		on_req <= 2'b01;
		tick(12);
		on_req <= 2'b00;
		tick(6);
		check(32'({sense_valid_out_n, sense_hold}), 32'h3, "hold off");
		retry();
		check(32'(clr_n > n), 32'h1, "lighting retry");
		apb(1'b1, `ADDR_CHCFG, 32'h800);
		retry();
		check(32'(clr_n == n), 32'h1, "motor retry");
		on_req <= 2'b01;
		tick(8);
		on_req <= 2'b00;
		tick(6);
		check(32'(clr_n > n), 32'h1, "motor clean off");
		apb(1'b1, `ADDR_OCCFG, 32'h1);
		apb(1'b1, `ADDR_CHCFG, 32'h400);
		n = chk_n;
		on_req <= 2'b01;
		tick(70);
		check(32'(chk_n == n), 32'h1, "slow slew check");
		apb(1'b1, `ADDR_CHCFG, 32'h600);
		on_req <= 2'b00;
		tick(4);
		on_req <= 2'b01;
		tick(70);
		check(32'(chk_n > n), 32'h1, "periodic check");
		open_load_on_det <= 2'b01;
		tick(60);
		rd(`ADDR_FAULT, 32'h1, "periodic open_load_on_flag set");
		rd(`ADDR_FAULT, 32'h1, "open_load_on_flag held");
		open_load_on_det <= 2'b00;
		tick(60);
		rd(`ADDR_FAULT, 32'h1, "open_load_on_flag before clean read");
		rd(`ADDR_FAULT, 32'h0, "open_load_on_flag clean cleared");
		rd(`ADDR_STATE, 32'h100, "status word");
		apb(1'b1, `ADDR_CHCFG, 32'h200);
		open_load_on_det <= 2'b01;
		tick(4);
		on_req <= 2'b00;
		tick(6);
		rd(`ADDR_FAULT, 32'h1, "direct check");
		open_load_on_det <= 2'b00;
		tick(4);
		end_of_test();
	end
endmodule : switch_diag_and_sense_ctrl_bench
